/* rtl/fbh_cycle.sv */
// one asynchronous bus cycle (read or write) on the flash pins
`timescale 1ns/10ps
`default_nettype none
module fbh_cycle (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  input  wire logic              start_i,
  input  wire logic              wr_i,
  input  wire logic [18:0]       addr_i,
  input  wire logic [7:0]        data_i,
  input  wire logic              hv_i,
  input  wire logic [7:0]        dq_sync_i,
  output logic                   done_o,
  output logic [7:0]             rdata_o,
  output fbh_pkg::fbh_pins_t     pins_o
);
  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_STRB  = 2'b10,
    CY_HOLD  = 2'b11
  } fbh_cy_t;

  fbh_cy_t    state;
  logic [3:0] cnt;
  logic       wr;

  // setup -> strobe -> hold; chip select frames the strobe so the write
  // edge ordering is address on falling write strobe, data on its rise
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= CY_IDLE;
      cnt   <= 4'h0;
      wr    <= 1'b0;
    end else begin
      case (state)
        CY_IDLE: begin
          if (start_i) begin
            state <= CY_SETUP;
            wr    <= wr_i;
            cnt   <= 4'(fbh_pkg::SETUP_CYC);
          end
        end
        CY_SETUP: begin
          if (cnt == fbh_pkg::CNT_ONE) begin
            state <= CY_STRB;
            cnt   <= wr ? 4'(fbh_pkg::WP_CYC) : 4'(fbh_pkg::ACC_CYC + 1);
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        CY_STRB: begin
          if (cnt == fbh_pkg::CNT_ONE) begin
            state <= CY_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: state <= CY_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_o <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, hv: 1'b0, addr: '0,
                  dq: '0, dq_oe_b: 1'b1};
    end else begin
      case (state)
        CY_IDLE: begin
          if (start_i) begin
            pins_o.addr    <= addr_i;
            pins_o.dq      <= data_i;
            pins_o.hv      <= hv_i;
            pins_o.ce_b    <= 1'b0;
            pins_o.dq_oe_b <= !wr_i;
          end
        end
        CY_SETUP: begin
          if (cnt == fbh_pkg::CNT_ONE) begin
            // gate is already high before the strobe falls, so no gate-rise write start
            pins_o.oe_b <= wr;  // write keeps output gate high
            pins_o.we_b <= !wr; // write strobe low with chip select low
          end
        end
        CY_STRB: begin
          if (cnt == fbh_pkg::CNT_ONE) begin
            // strobe rises before chip select, so it owns the data latch
            pins_o.we_b <= 1'b1;
            pins_o.oe_b <= 1'b1;
          end
        end
        default: begin
          pins_o.ce_b    <= 1'b1;
          pins_o.dq_oe_b <= 1'b1;
          pins_o.hv      <= 1'b0;
        end
      endcase
    end
  end

  // sample read data at the end of the access window, gates still low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= (state == CY_HOLD);
      if (state == CY_STRB && cnt == fbh_pkg::CNT_ONE && !wr) begin
        rdata_o <= dq_sync_i;
      end
    end
  end

  AST_WR_GATE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !pins_o.we_b |-> (pins_o.oe_b && !pins_o.ce_b && !pins_o.dq_oe_b))
    else $error("write strobe low without write conditions");
  AST_NO_FIGHT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !pins_o.oe_b |-> pins_o.dq_oe_b)
    else $error("host drives data while flash output gate is low");
  AST_WE_RISE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(pins_o.we_b) |-> !pins_o.ce_b)
    else $error("chip select rose before write strobe");
  AST_WE_FALL: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(pins_o.we_b) |-> $past(!pins_o.ce_b))
    else $error("write strobe fell before chip select");
  AST_DONE_BOUND: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (start_i && state == CY_IDLE) |-> ##[3:12] done_o)
    else $error("bus cycle did not finish in time");
  COV_WRITE: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(pins_o.we_b));
  COV_READ:  cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(pins_o.oe_b));
endmodule : fbh_cycle
`default_nettype wire

/* rtl/fbh_host.sv */
// flash bus host controller: reads, command writes and autoselect sequences
// What this block does
// - data is read only while chip select and output gate are both low
// - hardware identify: raise the high-voltage pin with address bit nine held low, one read per request with bit zero taken from the request
// - write: strobe low while chip select low and output gate high
// - strobe never low while output gate low; no write is started by the gate rising
// - autoselect entered by three unlock writes, left only by reset command
`timescale 1ns/10ps
`default_nettype none
module fbh_host (
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  input  wire logic               req_valid_i,
  input  wire fbh_pkg::fbh_req_t  req_i,
  output logic                    req_ready_o,
  output logic                    rsp_valid_o,
  output logic [7:0]              rsp_data_o,
  output logic                    rsp_par_ok_o,
  output logic                    autosel_o,
  output logic                    ce_b_o,
  output logic                    oe_b_o,
  output logic                    we_b_o,
  output logic                    id_hv_o,
  output logic [18:0]             addr_o,
  output logic [7:0]              dq_o,
  output logic                    dq_oe_b_o,
  input  wire logic [7:0]         dq_i
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN  = 2'b01,
    HS_WAIT = 2'b10,
    HS_RESP = 2'b11
  } fbh_hs_t;

  // odd parity over all eight bits of an identification byte
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ^b;
  endfunction : odd_par

  fbh_hs_t             state;
  fbh_pkg::fbh_req_t   cur;
  logic [1:0]          step;
  logic [1:0]          last_step;
  logic                cy_start;
  logic                cy_done;
  logic [7:0]          cy_rdata;
  fbh_pkg::fbh_pins_t  pins;
  logic [7:0]          dq_m0;
  logic [7:0]          dq_m1;
  logic [7:0]          dq_m2;
  logic [7:0]          dq_stable;
  logic [18:0]         next_addr;
  logic [7:0]          next_data;
  logic                next_hv;

  // data pins cross in from the flash; accept a value once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_m0     <= 8'h00;
      dq_m1     <= 8'h00;
      dq_m2     <= 8'h00;
      dq_stable <= 8'h00;
    end else begin
      dq_m0 <= dq_i;
      dq_m1 <= dq_m0;
      dq_m2 <= dq_m1;
      if (dq_m1 == dq_m2) begin
        dq_stable <= dq_m2;
      end
    end
  end

  // per-step address and data of each operation
  always_comb begin
    next_addr = cur.addr;
    next_data = cur.data;
    next_hv   = 1'b0;
    case (cur.op)
      fbh_pkg::OP_AS_ENTR, fbh_pkg::OP_AS_EXIT: begin
        // three unlock writes; command register sits at no array address
        case (step)
          2'd0: begin
            next_addr = fbh_pkg::CMD_ADDR_A;
            next_data = fbh_pkg::CMD_UNLK_A;
          end
          2'd1: begin
            next_addr = fbh_pkg::CMD_ADDR_B;
            next_data = fbh_pkg::CMD_UNLK_B;
          end
          default: begin
            next_addr = fbh_pkg::CMD_ADDR_A;
            next_data = (cur.op == fbh_pkg::OP_AS_ENTR) ? fbh_pkg::CMD_AUTOSEL
                                                        : fbh_pkg::CMD_RESET;
          end
        endcase
      end
      fbh_pkg::OP_HV_ID: begin
        // only bits zero, one, six and the sector bits matter; keep the rest low
        next_addr = 19'h0_0000;
        next_addr[0] = cur.addr[0];
        next_addr[1] = cur.addr[1];
        next_addr[fbh_pkg::BIT_SIX] = cur.addr[fbh_pkg::BIT_SIX];
        next_addr[18:16] = cur.addr[18:16]; // sector for protection verify
        next_hv = 1'b1;
      end
      default: begin
        next_hv = 1'b0; // plain read or write at full address
      end
    endcase
  end

  assign last_step = (cur.op == fbh_pkg::OP_AS_ENTR || cur.op == fbh_pkg::OP_AS_EXIT)
                     ? 2'd2 : 2'd0;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= HS_IDLE;
      cur      <= '0;
      step     <= 2'd0;
      cy_start <= 1'b0;
    end else begin
      cy_start <= 1'b0;
      case (state)
        HS_IDLE: begin
          if (req_valid_i) begin
            cur   <= req_i;
            step  <= 2'd0;
            state <= HS_RUN;
          end
        end
        HS_RUN: begin
          cy_start <= 1'b1;
          state    <= HS_WAIT;
        end
        HS_WAIT: begin
          if (cy_done) begin
            if (step == last_step) begin
              state <= HS_RESP;
            end else begin
              step  <= step + 2'd1;
              state <= HS_RUN;
            end
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // flash powers up in read state, so the host starts outside autoselect
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      autosel_o <= 1'b0;
    end else if (state == HS_RESP) begin
      if (cur.op == fbh_pkg::OP_AS_ENTR) begin
        autosel_o <= 1'b1;
      end else if (cur.op == fbh_pkg::OP_AS_EXIT) begin
        autosel_o <= 1'b0; // only the reset command leaves it
      end
    end
  end

  // parity flag checks identification bytes; protect reads give 01/00
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_ready_o  <= 1'b0;
      rsp_valid_o  <= 1'b0;
      rsp_data_o   <= 8'h00;
      rsp_par_ok_o <= 1'b0;
    end else begin
      req_ready_o <= (state == HS_IDLE) && !req_valid_i;
      rsp_valid_o <= (state == HS_RESP);
      if (state == HS_RESP) begin
        rsp_data_o   <= cy_rdata;
        rsp_par_ok_o <= odd_par(cy_rdata);
      end
    end
  end

  fbh_cycle u_cycle (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .start_i   (cy_start),
    .wr_i      (cur.op != fbh_pkg::OP_READ && cur.op != fbh_pkg::OP_HV_ID),
    .addr_i    (next_addr),
    .data_i    (next_data),
    .hv_i      (next_hv),
    .dq_sync_i (dq_stable),
    .done_o    (cy_done),
    .rdata_o   (cy_rdata),
    .pins_o    (pins)
  );

  // pins come straight from the cycle engine's flops; chip select is the
  // frame, so the host deselects and releases data between the steps of an operation
  assign ce_b_o    = pins.ce_b;
  assign oe_b_o    = pins.oe_b;
  assign we_b_o    = pins.we_b;
  assign id_hv_o   = pins.hv;
  assign addr_o    = pins.addr;
  assign dq_o      = pins.dq;
  assign dq_oe_b_o = pins.dq_oe_b;

  AST_AS_SEQ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(autosel_o) |-> $past(cur.op == fbh_pkg::OP_AS_ENTR))
    else $error("autoselect flag set without entry sequence");
  AST_AS_EXIT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $fell(autosel_o) |-> $past(cur.op == fbh_pkg::OP_AS_EXIT))
    else $error("autoselect left without reset command");
  AST_HV_READ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    id_hv_o |-> (we_b_o && addr_o[fbh_pkg::BIT_NINE] == 1'b0))
    else $error("high voltage during write or with bit nine driven");
  // an identifier read must come back with odd parity flagged good
  AST_PAR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (rsp_valid_o && cur.op == fbh_pkg::OP_HV_ID) |-> rsp_par_ok_o)
    else $error("identifier byte returned without odd parity");
  AST_RESP_ONE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("response held longer than one cycle");
  COV_AS_ENTER: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(autosel_o));
  COV_HV: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(id_hv_o));
  COV_RESP: cover property (@(posedge mclk_i) disable iff (!rst_b_i) rsp_valid_o && autosel_o);
endmodule : fbh_host
`default_nettype wire

/* rtl/fbh_pkg.sv */
// package: shared constants and types for the flash bus host controller
package fbh_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  // command addresses and data bytes of the unlock and autoselect sequences
  localparam logic [18:0] CMD_ADDR_A  = 19'h0_5555;
  localparam logic [18:0] CMD_ADDR_B  = 19'h0_2AAA;
  localparam logic [7:0]  CMD_UNLK_A  = 8'hAA;
  localparam logic [7:0]  CMD_UNLK_B  = 8'h55;
  localparam logic [7:0]  CMD_AUTOSEL = 8'h90;
  localparam logic [7:0]  CMD_RESET   = 8'hF0;
  // autoselect low addresses
  localparam logic [18:0] AS_MAKER    = 19'h0_0000;
  localparam logic [18:0] AS_PART     = 19'h0_0001;
  localparam logic [18:0] AS_PROT     = 19'h0_0002;
  localparam logic [18:0] AS_UNPROT   = 19'h0_0042;
  localparam int SECT_LSB = 16;
  localparam int BIT_SIX  = 6;
  localparam int BIT_NINE = 9;
  // bus timing: access time and strobe widths in ns, converted to 25 ns cycles
  localparam int CLK_NS     = 25;
  localparam int T_ACC_NS   = 150;
  localparam int T_WP_NS    = 50;
  localparam int T_SETUP_NS = 25;
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_WRITE   = 3'b001,
    OP_AS_ENTR = 3'b010,
    OP_AS_EXIT = 3'b011,
    OP_HV_ID   = 3'b100
  } fbh_op_t;

  typedef struct packed {
    fbh_op_t     op;
    logic [18:0] addr;
    logic [7:0]  data;
  } fbh_req_t;

  typedef struct packed {
    logic        ce_b;
    logic        oe_b;
    logic        we_b;
    logic        hv;
    logic [18:0] addr;
    logic [7:0]  dq;
    logic        dq_oe_b;
  } fbh_pins_t;
endpackage : fbh_pkg

/* tb/fbh_flash_model.sv */
// behavioural byte-wide flash device seen from its pins
`timescale 1ns/10ps
`default_nettype none
module fbh_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h02, // arbitrary value, odd parity
  parameter logic [7:0] PART_ID  = 8'hB5  // arbitrary value, odd parity
) (
  input  wire logic        ce_b_i,
  input  wire logic        oe_b_i,
  input  wire logic        we_b_i,
  input  wire logic        id_hv_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        dq_oe_b_i,
  input  wire logic [7:0]  prot_i,
  output logic [7:0]       dq_o,
  output logic             autosel_o,
  output logic [18:0]      lat_addr_o,
  output logic [7:0]       lat_data_o,
  output logic             clash_o
);
  logic [1:0] step;
  logic       wr_on;
  logic       sel;
  logic [7:0] rd_val;
  initial begin
    step = 2'd0;
    autosel_o = 1'b0;
    wr_on = 1'b0;
    lat_addr_o = '0;
    lat_data_o = '0;
    clash_o = 1'b0;
  end
  // sector bits are don't care for command addresses
  task automatic command(input logic [18:0] a, input logic [7:0] d);
    if (step == 2'd2 && a[14:0] == 15'h5555 && d == 8'h90) begin
      autosel_o = 1'b1;
      step = 2'd0;
    end else if (d == 8'hF0) begin
      autosel_o = 1'b0;
      step = 2'd0;
    end else if (step == 2'd0 && a[14:0] == 15'h5555 && d == 8'hAA) begin
      step = 2'd1;
    end else if (step == 2'd1 && a[14:0] == 15'h2AAA && d == 8'h55) begin
      step = 2'd2;
    end else begin
      step = 2'd0;
    end
  endtask : command
  always @(negedge we_b_i or negedge ce_b_i) begin
    if (!we_b_i && !ce_b_i && oe_b_i) begin
      lat_addr_o = addr_i;
      wr_on = 1'b1;
    end
  end
  always @(posedge oe_b_i) begin
    if (!we_b_i && !ce_b_i) begin
      lat_addr_o = addr_i;
      wr_on = 1'b1;
    end
  end
  // a deselect only closes the write; nothing already started is dropped
  always @(posedge we_b_i or posedge ce_b_i) begin
    if (wr_on) begin
      wr_on = 1'b0;
      lat_data_o = dq_i;
      command(lat_addr_o, dq_i);
    end
  end
  always @(negedge oe_b_i or negedge dq_oe_b_i) begin
    if (!oe_b_i && !ce_b_i && !dq_oe_b_i) clash_o = 1'b1;
  end
  always @* begin
    sel = !ce_b_i && !oe_b_i;
    if (id_hv_i || autosel_o) begin
      case ({addr_i[6], addr_i[1], addr_i[0]})
        3'b000:  rd_val = MAKER_ID;
        3'b001:  rd_val = PART_ID;
        3'b010:  rd_val = {7'h00, prot_i[addr_i[18:16]]};
        3'b110:  rd_val = prot_i[addr_i[18:16]] ? 8'h01 : 8'h00;
        default: rd_val = 8'h00;
      endcase
    end else begin
      rd_val = addr_i[7:0] ^ {addr_i[18:16], addr_i[12:8]};
    end
  end
  // released pins show the inverse so a stale sample cannot pass
  assign #40 dq_o = sel ? rd_val : ~rd_val;
endmodule : fbh_flash_model
`default_nettype wire

/* tb/test_fbh_host.sv */
// self-checking testbench of the flash bus host controller
`timescale 1ns/10ps
`default_nettype none
`define FBH_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_fbh_host;
  logic              mclk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              req_valid_i = 1'b0;
  fbh_pkg::fbh_req_t req_i = '0;
  logic [7:0]        prot = 8'b1010_0110;
  logic              req_ready, rsp_valid, par_ok, autosel, ce_b, oe_b, we_b, hv, dq_oe_b;
  logic [7:0]        rsp_data, host_dq, flash_dq, lat_data;
  logic [18:0]       addr, lat_addr;
  logic              m_autosel, clash;
  wire  [7:0]        dq_bus = dq_oe_b ? flash_dq : host_dq;
  int                n_fail = 0;
  int                n_compared = 0;
  always #12.5 mclk_i = ~mclk_i;
  fbh_host u_fbh_host (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
    .rsp_par_ok_o(par_ok), .autosel_o(autosel), .ce_b_o(ce_b), .oe_b_o(oe_b), .we_b_o(we_b),
    .id_hv_o(hv), .addr_o(addr), .dq_o(host_dq), .dq_oe_b_o(dq_oe_b), .dq_i(dq_bus));
  fbh_flash_model u_fbh_flash_model (.ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b),
    .id_hv_i(hv), .addr_i(addr), .dq_i(dq_bus), .dq_oe_b_i(dq_oe_b), .prot_i(prot),
    .dq_o(flash_dq), .autosel_o(m_autosel), .lat_addr_o(lat_addr), .lat_data_o(lat_data),
    .clash_o(clash));
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic tick;
    @(posedge mclk_i);
    #2;
  endtask : tick
  task automatic xfer(input fbh_pkg::fbh_op_t op, input logic [18:0] a, input logic [7:0] d);
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 50) begin
      tick();
      i++;
    end
    if (req_ready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    req_i = '{op: op, addr: a, data: d};
    req_valid_i = 1'b1;
    tick();
    req_valid_i = 1'b0;
    while (rsp_valid !== 1'b1 && i < 300) begin
      tick();
      i++;
    end
    if (rsp_valid !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask : xfer
  function automatic logic [7:0] arr_byte(input logic [18:0] a);
    return a[7:0] ^ {a[18:16], a[12:8]};
  endfunction : arr_byte
  task automatic t_reset;
    repeat (12) tick();
    `FBH_CHK({ce_b, oe_b, we_b, dq_oe_b, hv, autosel}, 6'b11_1100)
    rst_b_i = 1'b1;
    tick();
    tick();
    `FBH_CHK(req_ready, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task automatic t_read;
    logic [18:0] al [5];
    al = '{19'h0_0000, 19'h0_FFFF, 19'h1_0000, 19'h7_FFFF, 19'h5_A5C3};
    foreach (al[k]) begin
      xfer(fbh_pkg::OP_READ, al[k], 8'h00);
      `FBH_CHK(rsp_data, arr_byte(al[k]))
    end
    $display("test read done");
  endtask : t_read
  task automatic t_hv_id;
    xfer(fbh_pkg::OP_HV_ID, 19'h7_FF38, 8'h00);
    `FBH_CHK(rsp_data, u_fbh_flash_model.MAKER_ID)
    `FBH_CHK({par_ok, ^rsp_data}, 2'b11)
    xfer(fbh_pkg::OP_HV_ID, 19'h2_AB39, 8'h00);
    `FBH_CHK(rsp_data, u_fbh_flash_model.PART_ID)
    `FBH_CHK({par_ok, ^rsp_data, autosel}, 3'b110)
    $display("test identify done");
  endtask : t_hv_id
  task automatic t_autosel;
    xfer(fbh_pkg::OP_AS_ENTR, 19'h0_0000, 8'h00);
    `FBH_CHK({autosel, m_autosel}, 2'b11)
    `FBH_CHK({lat_addr[14:0], lat_data}, {15'h5555, 8'h90})
    xfer(fbh_pkg::OP_READ, 19'h3_0000, 8'h00);
    `FBH_CHK(rsp_data, u_fbh_flash_model.MAKER_ID)
    xfer(fbh_pkg::OP_READ, 19'h0_0001, 8'h00);
    `FBH_CHK(rsp_data, u_fbh_flash_model.PART_ID)
    for (int s = 0; s < 8; s++) begin
      xfer(fbh_pkg::OP_READ, {s[2:0], 16'h0002}, 8'h00);
      `FBH_CHK(rsp_data, {7'h00, prot[s]})
      xfer(fbh_pkg::OP_READ, {s[2:0], 16'h0042}, 8'h00);
      if (!prot[s]) `FBH_CHK(rsp_data, 8'h00)
    end
    xfer(fbh_pkg::OP_AS_EXIT, 19'h0_0000, 8'h00);
    `FBH_CHK({autosel, m_autosel}, 2'b00)
    xfer(fbh_pkg::OP_READ, 19'h6_0102, 8'h00);
    `FBH_CHK(rsp_data, arr_byte(19'h6_0102))
    $display("test autoselect done");
  endtask : t_autosel
  task automatic t_write;
    xfer(fbh_pkg::OP_WRITE, 19'h3_1234, 8'hC3);
    `FBH_CHK(lat_addr, 19'h3_1234)
    `FBH_CHK(lat_data, 8'hC3)
    xfer(fbh_pkg::OP_WRITE, 19'h0_5555, 8'hAA);
    xfer(fbh_pkg::OP_READ, 19'h1_0203, 8'h00);
    `FBH_CHK(rsp_data, arr_byte(19'h1_0203))
    `FBH_CHK({clash, m_autosel}, 2'b00)
    $display("test write done");
  endtask : t_write
  initial begin
    t_reset();
    t_read();
    t_hv_id();
    t_autosel();
    t_write();
    conclude();
  end
endmodule : test_fbh_host
`default_nettype wire
